// *** logic/pbs_cpu_end.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Processor end of the parity-signalling backplane link
// ****************************************************************
module pbs_cpu_end (
  input  wire logic                           I_CORE_CLK,       // Core clock
  input  wire logic                           I_RST,            // Sync reset
  input  wire logic                           I_CLK_EN,         // Clock enable
  input  wire logic                           I_REQ,            // Request valid
  input  wire logic                           I_WRITE,          // 1 = write
  input  wire logic [pbs_pkg::ADDR_W-1:0]     I_ADDR,           // 18-bit address
  input  wire logic [pbs_pkg::DATA_W-1:0]     I_WDATA,          // Write data
  output logic                                O_READY,          // Can take request
  output logic                                O_DONE,           // Cycle completed
  output logic [pbs_pkg::DATA_W-1:0]          O_RDATA,          // Read data
  output logic                                O_PARITY_STATUS,  // Line 16 on last read
  output logic                                O_TRAP,           // Parity trap taken
  output logic [8:0]                          O_TRAP_VECTOR,    // Trap vector
  output logic [pbs_pkg::IRQ_LEVELS-1:0]      O_IRQ_LEVEL,      // Requests 4..7
  pbs_bus_if.cpu                              bus               // Link
);

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_HOLD, ST_DATA,
                            ST_SAMPLE, ST_END} pbs_cpu_state_t;

  pbs_cpu_state_t                 state_q;    // Cycle state
  logic [pbs_pkg::ADDR_W-1:0]     dal_m_q;    // Line sync stage 1
  logic [pbs_pkg::ADDR_W-1:0]     dal_s_q;    // Line sync stage 2
  logic                           reply_m_q;  // Reply sync stage 1
  logic                           reply_s_q;  // Reply sync stage 2
  logic [pbs_pkg::IRQ_LEVELS-1:0] irq_m_q;    // Request sync stage 1
  logic [pbs_pkg::IRQ_LEVELS-1:0] irq_s_q;    // Request sync stage 2
  logic [pbs_pkg::ADDR_W-1:0]     addr_q;     // Latched address
  logic [pbs_pkg::DATA_W-1:0]     wdata_q;    // Latched write data
  logic                           write_q;    // Latched direction
  logic [pbs_pkg::CNT_W-1:0]      cnt_q;      // Phase counter
  logic                           sync_q;     // Sync drive
  logic                           din_q;      // Read strobe drive
  logic                           dout_q;     // Write strobe drive
  logic [pbs_pkg::ADDR_W-1:0]     out_q;      // Line drive value
  logic [pbs_pkg::ADDR_W-1:0]     oe_q;       // Line drive enable
  logic                           sample_now; // Parity sample instant
  logic                           trap_hit;   // Both parity lines asserted

  assign bus.dal_cpu_out = out_q;
  assign bus.dal_cpu_oe  = oe_q;
  assign bus.sync        = sync_q;
  assign bus.din         = din_q;
  assign bus.dout        = dout_q;

  // Ready only between cycles
  assign O_READY = (state_q == ST_IDLE);

  // Sample instant falls a fixed count after reply is seen
  assign sample_now = (state_q == ST_SAMPLE) && (cnt_q == pbs_pkg::CNT_ZERO);

  // Both lines asserted in the data phase of our own read
  assign trap_hit = dal_s_q[pbs_pkg::LINE_TRAP_ENABLE] &
                    dal_s_q[pbs_pkg::LINE_PARITY_STATUS];

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Lines and reply share latency, so a sampled line matches bus time
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      dal_m_q   <= 18'h00000;
      dal_s_q   <= 18'h00000;
      reply_m_q <= 1'b0;
      reply_s_q <= 1'b0;
      irq_m_q   <= 4'h0;
      irq_s_q   <= 4'h0;
    end else if (I_CLK_EN) begin
      dal_m_q   <= bus.dal;
      dal_s_q   <= dal_m_q;
      reply_m_q <= bus.bus_reply_handshake;
      reply_s_q <= reply_m_q;
      irq_m_q   <= bus.irq;
      irq_s_q   <= irq_m_q;
    end
  end

  // ****************************************************************
  // Interrupt request levels
  // ****************************************************************
  // Four extra request lines give levels 4..7, bit 0 = level 4
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_IRQ_LEVEL <= 4'h0;
    end else if (I_CLK_EN) begin
      O_IRQ_LEVEL <= irq_s_q;
    end
  end

  // ****************************************************************
  // Bus cycle state machine
  // ****************************************************************
  // Address setup, sync, address hold, data strobe, sample, release
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      state_q <= ST_IDLE;
      addr_q  <= 18'h00000;
      wdata_q <= 16'h0000;
      write_q <= 1'b0;
      cnt_q   <= pbs_pkg::CNT_ZERO;
      sync_q  <= 1'b0;
      din_q   <= 1'b0;
      dout_q  <= 1'b0;
      out_q   <= 18'h00000;
      oe_q    <= 18'h00000;
    end else if (I_CLK_EN) begin
      case (state_q)
        // Take a request and start driving the full address
        ST_IDLE: begin
          if (I_REQ) begin
            addr_q  <= I_ADDR;
            wdata_q <= I_WDATA;
            write_q <= I_WRITE;
            out_q   <= I_ADDR;
            oe_q    <= 18'h3FFFF;
            cnt_q   <= pbs_pkg::SETUP_CNT;
            state_q <= ST_SETUP;
          end
        end
        // Address setup before sync
        ST_SETUP: begin
          if (cnt_q == pbs_pkg::CNT_ZERO) begin
            sync_q  <= 1'b1;
            cnt_q   <= pbs_pkg::HOLD_CNT;
            state_q <= ST_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        // Address hold after sync, then enter the data phase
        ST_HOLD: begin
          if (cnt_q != pbs_pkg::CNT_ZERO) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (write_q) begin
            // Write data on 15:0 only; 17:16 are left to the controller
            out_q   <= {2'h0, wdata_q};
            oe_q    <= 18'h0FFFF;
            dout_q  <= 1'b1;
            state_q <= ST_DATA;
          end else begin
            // Read: release every line for the memory end
            oe_q    <= 18'h00000;
            din_q   <= 1'b1;
            state_q <= ST_DATA;
          end
        end
        // Wait for the reply handshake
        ST_DATA: begin
          if (reply_s_q && write_q) begin
            // Writes never trap, whatever line 16 shows
            dout_q  <= 1'b0;
            oe_q    <= 18'h00000;
            state_q <= ST_END;
          end else if (reply_s_q) begin
            cnt_q   <= pbs_pkg::SAMPLE_CNT;
            state_q <= ST_SAMPLE;
          end
        end
        // Count to the sample instant, then finish or abort
        ST_SAMPLE: begin
          if (!sample_now) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (trap_hit) begin
            // Abort: drop sync and strobe together
            din_q   <= 1'b0;
            sync_q  <= 1'b0;
            state_q <= ST_END;
          end else begin
            din_q   <= 1'b0;
            state_q <= ST_END;
          end
        end
        // Wait for the reply to drop, then end the cycle
        ST_END: begin
          if (!reply_s_q) begin
            sync_q  <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // User-side results
  // ****************************************************************
  // Completion and trap pulses, read data and parity status
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_DONE          <= 1'b0;
      O_TRAP          <= 1'b0;
      O_RDATA         <= 16'h0000;
      O_PARITY_STATUS <= 1'b0;
      O_TRAP_VECTOR   <= 9'h000;
    end else if (I_CLK_EN) begin
      O_DONE <= 1'b0;
      O_TRAP <= 1'b0;
      if ((state_q == ST_DATA) && reply_s_q && write_q) begin
        O_DONE <= 1'b1;
      end else if (sample_now && trap_hit) begin
        O_TRAP        <= 1'b1;
        O_TRAP_VECTOR <= pbs_pkg::PARITY_TRAP_VECTOR;
      end else if (sample_now) begin
        O_DONE          <= 1'b1;
        O_RDATA         <= dal_s_q[pbs_pkg::DATA_W-1:0];
        O_PARITY_STATUS <= dal_s_q[pbs_pkg::LINE_PARITY_STATUS];
      end
    end
  end

endmodule : pbs_cpu_end
`default_nettype wire

// *** logic/pbs_pkg.sv ***
`default_nettype none
// ****************************************************************
// Shared constants for the parity-signalling backplane link
// ****************************************************************
package pbs_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS  = 40000;  // Core clock period, 25 MHz
  localparam int ADDR_SETUP_NS  = 150;    // Address valid before sync
  localparam int ADDR_HOLD_NS   = 100;    // Address held after sync
  localparam int SAMPLE_MIN_NS  = 250;    // Earliest parity sample after reply
  localparam int SAMPLE_MAX_NS  = 300;    // Latest parity sample after reply

  // Least times round up, longest times round down
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ADDR_HOLD_CYC  = (ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SAMPLE_MIN_CYC = (SAMPLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SAMPLE_MAX_CYC = (SAMPLE_MAX_NS * 1000) / CLK_PERIOD_PS;

  localparam int CNT_W = 4;  // Width of the phase counters
  localparam logic [CNT_W-1:0] SETUP_CNT  = CNT_W'(ADDR_SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_CNT   = CNT_W'(ADDR_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] SAMPLE_CNT = CNT_W'(SAMPLE_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] MEM_REPLY_CNT   = 4'h1;  // Far-end delay before read reply
  localparam logic [CNT_W-1:0] MEM_CAPTURE_CNT = 4'h3;  // Write capture settle time
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  // ****************************************************************
  // Line layout
  // ****************************************************************
  localparam int ADDR_W = 18;  // Full address width
  localparam int DATA_W = 16;  // Data width
  localparam int LINE_PARITY_STATUS = 16;  // Parity status line
  localparam int LINE_TRAP_ENABLE   = 17;  // Parity trap enable line
  localparam int IRQ_LEVELS = 4;           // Interrupt request levels 4..7

  // ****************************************************************
  // Trap and memory
  // ****************************************************************
  localparam logic [8:0] PARITY_TRAP_VECTOR = 9'h04C;  // 114 octal
  localparam int MEM_AW    = 8;    // Word index width of the far-end store
  localparam int MEM_WORDS = 256;  // Words in the far-end store
  localparam int MEM_LSB   = 1;    // Byte-address bit of word index bit 0

endpackage : pbs_pkg
`default_nettype wire

// *** logic/pbs_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Backplane link between processor end and memory end
// ****************************************************************
interface pbs_bus_if;
  logic [pbs_pkg::ADDR_W-1:0]     dal_cpu_out;  // Processor drive value
  logic [pbs_pkg::ADDR_W-1:0]     dal_cpu_oe;   // Processor drive enable
  logic [pbs_pkg::ADDR_W-1:0]     dal_mem_out;  // Memory end drive value
  logic [pbs_pkg::ADDR_W-1:0]     dal_mem_oe;   // Memory end drive enable
  logic [pbs_pkg::ADDR_W-1:0]     dal;          // Resolved lines, 1 = asserted
  logic                           sync;         // Cycle framing from processor
  logic                           din;          // Read strobe from processor
  logic                           dout;         // Write strobe from processor
  logic                           bus_reply_handshake;  // Reply from memory end
  logic [pbs_pkg::IRQ_LEVELS-1:0] irq;          // Requests, bit 0 = level 4

  // Wired-OR of asserted drivers; released lines read negated
  assign dal = (dal_cpu_out & dal_cpu_oe) | (dal_mem_out & dal_mem_oe);

  modport cpu (output dal_cpu_out, output dal_cpu_oe, output sync, output din,
               output dout, input dal, input bus_reply_handshake, input irq);
  modport mem (output dal_mem_out, output dal_mem_oe, output bus_reply_handshake,
               output irq, input dal, input sync, input din, input dout);
endinterface : pbs_bus_if
`default_nettype wire

// *** logic/pbs_mem_end.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Memory board plus external parity controller end of the link
// ****************************************************************
module pbs_mem_end (
  input  wire logic                           I_CORE_CLK,            // Core clock
  input  wire logic                           I_RST,                 // Sync reset
  input  wire logic                           I_CLK_EN,              // Clock enable
  input  wire logic                           I_TRAP_ENABLE,         // Enable cpu trap
  input  wire logic                           I_WRITE_WRONG_PARITY,  // Diagnostic write
  input  wire logic                           I_FORCE_READ_ERROR,    // Report read error
  input  wire logic [pbs_pkg::IRQ_LEVELS-1:0] I_IRQ,                 // Requests 4..7
  output logic                                O_WR_STROBE,           // Word stored
  output logic [pbs_pkg::ADDR_W-1:0]          O_WR_ADDR,             // Stored address
  output logic [pbs_pkg::DATA_W-1:0]          O_WR_DATA,             // Stored data
  output logic                                O_WR_WRONG_PARITY,     // Stored bad parity
  output logic                                O_RD_STROBE,           // Read answered
  output logic                                O_RD_PARITY_ERROR,     // Error reported
  pbs_bus_if.mem                              bus                    // Link
);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RD_WAIT, ST_RD_DRIVE,
                            ST_WR_CAPT, ST_WR_REPLY} pbs_mem_state_t;

  pbs_mem_state_t                 state_q;        // Cycle state
  logic [2:0]                     ctl_m_q;        // Sync stage 1: sync, din, dout
  logic [2:0]                     ctl_s_q;        // Sync stage 2
  logic [pbs_pkg::ADDR_W-1:0]     dal_m_q;        // Line sync stage 1
  logic [pbs_pkg::ADDR_W-1:0]     dal_s_q;        // Line sync stage 2
  logic [pbs_pkg::ADDR_W-1:0]     addr_q;         // Latched address
  logic [pbs_pkg::CNT_W-1:0]      cnt_q;          // Phase counter
  logic                           reply_q;        // Reply drive
  logic [pbs_pkg::ADDR_W-1:0]     out_q;          // Line drive value
  logic [pbs_pkg::ADDR_W-1:0]     oe_q;           // Line drive enable
  logic [pbs_pkg::IRQ_LEVELS-1:0] irq_q;          // Request drive
  logic [pbs_pkg::DATA_W:0]       mem_q [pbs_pkg::MEM_WORDS];  // Bad-parity bit + data
  logic [pbs_pkg::MEM_AW-1:0]     idx;            // Word index of the cycle
  logic                           rd_err;         // Parity error on this read

  assign idx    = addr_q[pbs_pkg::MEM_LSB +: pbs_pkg::MEM_AW];
  assign rd_err = I_FORCE_READ_ERROR | mem_q[idx][pbs_pkg::DATA_W];

  assign bus.dal_mem_out         = out_q;
  assign bus.dal_mem_oe          = oe_q;
  assign bus.bus_reply_handshake = reply_q;
  assign bus.irq                 = irq_q;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Two flops on every processor-driven level
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctl_m_q <= 3'h0;
      ctl_s_q <= 3'h0;
      dal_m_q <= 18'h00000;
      dal_s_q <= 18'h00000;
    end else if (I_CLK_EN) begin
      ctl_m_q <= {bus.sync, bus.din, bus.dout};
      ctl_s_q <= ctl_m_q;
      dal_m_q <= bus.dal;
      dal_s_q <= dal_m_q;
    end
  end

  // ****************************************************************
  // Interrupt request drive
  // ****************************************************************
  // Requests for levels 4..7 on the extra bused lines
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      irq_q <= 4'h0;
    end else if (I_CLK_EN) begin
      irq_q <= I_IRQ;
    end
  end

  // ****************************************************************
  // Cycle state machine
  // ****************************************************************
  // Latches the address, answers reads and writes, drives lines 16/17
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      state_q           <= ST_IDLE;
      addr_q            <= 18'h00000;
      cnt_q             <= pbs_pkg::CNT_ZERO;
      reply_q           <= 1'b0;
      out_q             <= 18'h00000;
      oe_q              <= 18'h00000;
      O_WR_STROBE       <= 1'b0;
      O_WR_ADDR         <= 18'h00000;
      O_WR_DATA         <= 16'h0000;
      O_WR_WRONG_PARITY <= 1'b0;
      O_RD_STROBE       <= 1'b0;
      O_RD_PARITY_ERROR <= 1'b0;
    end else if (I_CLK_EN) begin
      O_WR_STROBE <= 1'b0;
      O_RD_STROBE <= 1'b0;
      case (state_q)
        // Address phase: all 18 lines are address, 17:16 included
        ST_IDLE: begin
          if (ctl_s_q[2]) begin
            addr_q  <= dal_s_q;
            state_q <= ST_ADDR;
          end
        end
        // Wait for a data strobe
        ST_ADDR: begin
          cnt_q <= pbs_pkg::MEM_REPLY_CNT;
          if (!ctl_s_q[2]) begin
            state_q <= ST_IDLE;
          end else if (ctl_s_q[1]) begin
            state_q <= ST_RD_WAIT;
          end else if (ctl_s_q[0]) begin
            // Controller asks for wrong parity during the write data phase
            out_q[pbs_pkg::LINE_PARITY_STATUS] <= I_WRITE_WRONG_PARITY;
            oe_q[pbs_pkg::LINE_PARITY_STATUS]  <= I_WRITE_WRONG_PARITY;
            cnt_q   <= pbs_pkg::MEM_CAPTURE_CNT;
            state_q <= ST_WR_CAPT;
          end
        end
        // Access delay before the read answer
        ST_RD_WAIT: begin
          if (cnt_q == pbs_pkg::CNT_ZERO) begin
            out_q <= {I_TRAP_ENABLE, rd_err, mem_q[idx][pbs_pkg::DATA_W-1:0]};
            // Status from memory, trap enable from controller, data phase only
            oe_q  <= {I_TRAP_ENABLE, rd_err, 16'hFFFF};
            reply_q           <= 1'b1;
            O_RD_STROBE       <= 1'b1;
            O_RD_PARITY_ERROR <= rd_err;
            state_q           <= ST_RD_DRIVE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        // Hold read data until the strobe drops (or the cycle aborts)
        ST_RD_DRIVE: begin
          if (!ctl_s_q[1]) begin
            oe_q    <= 18'h00000;
            reply_q <= 1'b0;
            // Wait for framing to drop so a held sync is not taken as new
            state_q <= ST_ADDR;
          end
        end
        // Let write data and own line 16 settle, then store
        ST_WR_CAPT: begin
          if (cnt_q == pbs_pkg::CNT_ZERO) begin
            // Line 17 carries no meaning here and is not looked at
            mem_q[idx] <= dal_s_q[pbs_pkg::DATA_W:0];
            O_WR_STROBE       <= 1'b1;
            O_WR_ADDR         <= addr_q;
            O_WR_DATA         <= dal_s_q[pbs_pkg::DATA_W-1:0];
            O_WR_WRONG_PARITY <= dal_s_q[pbs_pkg::LINE_PARITY_STATUS];
            reply_q           <= 1'b1;
            state_q           <= ST_WR_REPLY;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        // Release once the write strobe drops
        ST_WR_REPLY: begin
          if (!ctl_s_q[0]) begin
            oe_q    <= 18'h00000;
            reply_q <= 1'b0;
            // Wait for framing to drop so a held sync is not taken as new
            state_q <= ST_ADDR;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : pbs_mem_end
`default_nettype wire

// *** dv/pbs_link_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Link protocol checks
// ****************************************************************
module pbs_link_properties (
  input wire logic                       I_CORE_CLK,           // Core clock
  input wire logic                       I_RST,                // Sync reset
  input wire logic [pbs_pkg::ADDR_W-1:0] dal_cpu_oe,           // Processor enables
  input wire logic [pbs_pkg::ADDR_W-1:0] dal_mem_oe,           // Memory enables
  input wire logic [pbs_pkg::ADDR_W-1:0] dal,                  // Resolved lines
  input wire logic                       sync,                 // Cycle framing
  input wire logic                       din,                  // Read strobe
  input wire logic                       dout,                 // Write strobe
  input wire logic                       bus_reply_handshake   // Reply
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  // Address held on all lines before and at framing
  addr_setup_a: assert property ($rose(sync) |-> $past(dal_cpu_oe, 3) == 18'h3FFFF
    && dal_cpu_oe == 18'h3FFFF) else $error("address not driven at framing");
  // Processor lets go of every line while reading
  read_release_a: assert property (din |-> dal_cpu_oe == 18'h00000)
    else $error("processor drives lines during read");
  // Write data uses only the low sixteen lines
  write_width_a: assert property (dout |-> dal_cpu_oe == 18'h0FFFF)
    else $error("write data width wrong");
  // Upper lines from memory only outside processor address drive
  mem_parity_a: assert property (|dal_mem_oe[17:16] |-> dal_cpu_oe[17:16] == 2'b00)
    else $error("parity lines clash with address");
  // Reply only answers a strobe
  strobe_reply_a: assert property ($rose(bus_reply_handshake) |-> din || dout)
    else $error("reply without strobe");
  // Strobe held eight cycles after reply, then drops within three more
  sample_window_a: assert property ($rose(bus_reply_handshake) && din
    |-> din [*8] ##[1:3] !din) else $error("sample timing wrong");
  // Abort only when both upper lines asserted
  abort_cause_a: assert property ($fell(din) && $fell(sync)
    |-> $past(dal[17], 2) && $past(dal[16], 2)) else $error("abort without cause");
  // Write always completes with framing held
  write_normal_a: assert property ($fell(dout) |-> sync)
    else $error("write aborted");

  // Main scenarios reached
  abort_c: cover property ($fell(din) && $fell(sync));
  write_c: cover property ($fell(dout));
  read_c: cover property ($fell(din) && sync);
endmodule // pbs_link_properties
`default_nettype wire

// *** dv/bus_parity_error_signalling_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Both ends joined, driven from the user sides
// ****************************************************************
module bus_parity_error_signalling_tb;
  logic        clk = 1'b0, rst = 1'b1, en = 1'b1, req = 1'b0, wr = 1'b0;  // Controls
  logic        te = 1'b0, wwp = 1'b0, fre = 1'b0;                          // Far-end modes
  logic [17:0] addr = 18'h00000, waddr, g_wa;                               // Addresses
  logic [15:0] wdata = 16'h0000, rdata, wdat, g_wd;                         // Data
  logic [3:0]  irq_in = 4'h0, irq_out;                                      // Requests
  logic [8:0]  vec;                                                         // Trap vector
  logic        rdy, done, trap, pstat, wstb, wp_o, g_done, g_trap, g_wp;    // Status
  logic        rstb, rpe, g_rp;                                             // Read report
  int          num_errors = 0, n_tests = 0;                                 // Counters

  pbs_bus_if u_pbs_bus_if ();
  pbs_cpu_end u_pbs_cpu_end (.I_CORE_CLK(clk), .I_RST(rst), .I_CLK_EN(en), .I_REQ(req),
    .I_WRITE(wr), .I_ADDR(addr), .I_WDATA(wdata), .O_READY(rdy), .O_DONE(done),
    .O_RDATA(rdata), .O_PARITY_STATUS(pstat), .O_TRAP(trap), .O_TRAP_VECTOR(vec),
    .O_IRQ_LEVEL(irq_out), .bus(u_pbs_bus_if));
  pbs_mem_end u_pbs_mem_end (.I_CORE_CLK(clk), .I_RST(rst), .I_CLK_EN(en),
    .I_TRAP_ENABLE(te), .I_WRITE_WRONG_PARITY(wwp), .I_FORCE_READ_ERROR(fre),
    .I_IRQ(irq_in), .O_WR_STROBE(wstb), .O_WR_ADDR(waddr), .O_WR_DATA(wdat),
    .O_WR_WRONG_PARITY(wp_o), .O_RD_STROBE(rstb), .O_RD_PARITY_ERROR(rpe),
    .bus(u_pbs_bus_if));
  pbs_link_properties u_pbs_link_properties (.I_CORE_CLK(clk), .I_RST(rst),
    .dal_cpu_oe(u_pbs_bus_if.dal_cpu_oe), .dal_mem_oe(u_pbs_bus_if.dal_mem_oe),
    .dal(u_pbs_bus_if.dal), .sync(u_pbs_bus_if.sync), .din(u_pbs_bus_if.din),
    .dout(u_pbs_bus_if.dout), .bus_reply_handshake(u_pbs_bus_if.bus_reply_handshake));

  // Clock, 40 ns period
  initial forever #20 clk = ~clk;

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One cycle on the link, far-end modes set with the request
  task automatic xfer(input logic w, input logic [17:0] a, input logic [15:0] d,
                      input logic e, input logic p, input logic f);
    {g_done, g_trap, g_wp, g_rp, g_wa, g_wd} = '0;
    @(posedge clk);
    {req, wr, addr, wdata, te, wwp, fre} <= {1'b1, w, a, d, e, p, f};
    do @(posedge clk); while (!rdy);
    req <= 1'b0;
    repeat (60) begin
      @(posedge clk);
      #1;
      if (wstb) {g_wa, g_wd, g_wp} = {waddr, wdat, wp_o};
      if (rstb) g_rp = rpe;
      if (done | trap) begin
        {g_done, g_trap} = {done, trap};
        break;
      end
    end
    // A cycle that never ends counts as a mismatch
    if (!(g_done | g_trap)) begin
      num_errors++;
      $display("unexpected at %0t: no completion", $time);
    end
    $display("test at %0t ended", $time);
  endtask

  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    $display("unexpected at %0t: watchdog", $time);
    summarize;
  end

  // Test sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b1, 18'h3FF0E, 16'hBEEF, 1'b0, 1'b0, 1'b0);
    check(g_wa, 18'h3FF0E);
    check({g_done, g_trap, g_wp, g_wd}, {3'b100, 16'hBEEF});
    xfer(1'b1, 18'h1F0A0, 16'h5A5A, 1'b1, 1'b1, 1'b0);
    check(g_wp, 1'b1);
    check({g_done, g_trap}, 2'b10);
    xfer(1'b0, 18'h3FF0E, 16'h0000, 1'b0, 1'b0, 1'b0);
    check({g_done, g_trap, pstat, rdata}, {3'b100, 16'hBEEF});
    xfer(1'b0, 18'h3FF0E, 16'h0000, 1'b0, 1'b0, 1'b1);
    check({g_done, g_trap, pstat}, 3'b101);
    check(g_rp, 1'b1);
    xfer(1'b0, 18'h3FF0E, 16'h0000, 1'b1, 1'b0, 1'b0);
    check({g_done, g_trap, pstat}, 3'b100);
    xfer(1'b0, 18'h3FF0E, 16'h0000, 1'b1, 1'b0, 1'b1);
    check({g_done, g_trap, vec}, {2'b01, 9'h04C});
    xfer(1'b0, 18'h1F0A0, 16'h0000, 1'b1, 1'b0, 1'b0);
    check({g_done, g_trap}, 2'b01);
    @(posedge clk);
    irq_in <= 4'hA;
    repeat (6) @(posedge clk);
    check(irq_out, 4'hA);
    irq_in <= 4'h5;
    repeat (6) @(posedge clk);
    check(irq_out, 4'h5);
    // Clock enable low freezes the request path
    en <= 1'b0;
    irq_in <= 4'h3;
    repeat (6) @(posedge clk);
    check(irq_out, 4'h5);
    en <= 1'b1;
    repeat (6) @(posedge clk);
    check(irq_out, 4'h3);
    summarize;
  end
endmodule // bus_parity_error_signalling_tb
`default_nettype wire
